// ---- design/sensor_command_mailbox.sv ----
// Purpose: command mailbox, response, interrupt flags and result registers
// Assumes: serial front end presents byte reads and writes on one clock
// Notes:   interrupt pin is open drain, driven low only
module sensor_command_mailbox #(
  parameter int EXEC_CYCLES = mailbox_pkg::EXEC_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port from the serial front end
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // interrupt enables from the configuration registers
  input  wire logic        int_output_enable,
  input  wire logic        light_interrupt_enable,
  input  wire logic        cmd_interrupt_enable,
  // measurement engine
  input  wire logic        meas_busy,
  input  wire logic        vis_ready,
  input  wire logic        uv_ready,
  input  wire logic [15:0] visible_result_in,
  input  wire logic        ir_ready,
  input  wire logic [7:0]  infrared_result_in,
  input  wire logic        ir_overflow,
  input  wire logic        aux_overflow,
  // sequencer status and requests
  output logic             awake,
  output logic             auto_run,
  output logic             force_pulse,
  output logic             device_reset_pulse,
  // interrupt pin, open drain
  output logic             int_pin_out,
  output logic             int_pin_oe
);

  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad_exec_cycles
    $error("EXEC_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic cmd_known(input logic [7:0] code);
    cmd_known = (code == mailbox_pkg::CMD_NO_OPERATION)
             || (code == mailbox_pkg::CMD_RESET)
             || (code == mailbox_pkg::CMD_FORCE)
             || (code == mailbox_pkg::CMD_PAUSE)
             || (code == mailbox_pkg::CMD_AUTO);
  endfunction : cmd_known

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  command_q;
  logic [7:0]  response_q;
  logic [7:0]  response_d;
  logic        cmd_flag_q;
  logic        cmd_flag_d;
  logic [1:0]  light_field_q;
  logic [1:0]  light_field_d;
  logic [15:0] visible_q;
  logic [7:0]  infrared_q;
  logic        awake_q;
  logic        auto_q;
  logic        auto_d;
  logic        force_q;
  logic        reset_cmd_q;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire wr_cmd   = reg_wr && hit(reg_addr, mailbox_pkg::OFF_COMMAND);
  wire wr_resp  = reg_wr && hit(reg_addr, mailbox_pkg::OFF_RESPONSE);
  wire wr_flags = reg_wr && hit(reg_addr, mailbox_pkg::OFF_IRQ_FLAGS);
  wire wr_vis_l = reg_wr && hit(reg_addr, mailbox_pkg::OFF_VIS_LOW);
  wire wr_vis_h = reg_wr && hit(reg_addr, mailbox_pkg::OFF_VIS_HIGH);
  wire wr_ir_l  = reg_wr && hit(reg_addr, mailbox_pkg::OFF_IR_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // command execution

  logic exec_busy;
  logic exec_done;

  // a write while a command is still in flight is ignored and not queued
  wire exec_start = wr_cmd && !exec_busy;

  command_executor #(
    .EXEC_CYCLES (EXEC_CYCLES)
  ) u_exec (
    .clk       (clk),
    .rst       (rst),
    .start     (exec_start),
    .meas_busy (meas_busy),
    .busy      (exec_busy),
    .done      (exec_done)
  );

  wire       err_latched = response_q[mailbox_pkg::RESP_ERR_BIT];
  wire       is_no_op    = (command_q == mailbox_pkg::CMD_NO_OPERATION);
  wire       is_reset    = (command_q == mailbox_pkg::CMD_RESET);
  wire       is_clearing = is_no_op || is_reset;
  wire       is_known    = cmd_known(command_q);
  // while an error stands only the clearing commands take effect
  wire       cmd_taken   = exec_done && (!err_latched || is_clearing);
  wire       cmd_good    = cmd_taken && is_known;
  wire [3:0] cnt_next    = response_q[mailbox_pkg::RESP_CNT_MSB:0] + 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // response register

  always_comb begin
    response_d = response_q;
    if (wr_resp) begin
      response_d = reg_wdata;
    end
    if (cmd_taken) begin
      if (!is_known) begin
        response_d = mailbox_pkg::ERR_INVALID_CMD;
      end else if (is_reset) begin
        response_d = mailbox_pkg::RST_RESPONSE;
      end else if (err_latched) begin
        response_d = {4'h0, cnt_next};
      end else begin
        response_d = {4'h0, cnt_next};
      end
    end
    // measurement errors are reported even while idle; they carry the top bit
    if (ir_overflow) begin
      response_d = mailbox_pkg::ERR_IR_OVERFLOW;
    end else if (aux_overflow) begin
      response_d = mailbox_pkg::ERR_AUX_OVERFLOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // autonomous run control

  always_comb begin
    auto_d = auto_q;
    if (cmd_good && command_q == mailbox_pkg::CMD_AUTO) begin
      auto_d = 1'b1;
    end else if (cmd_good && (command_q == mailbox_pkg::CMD_PAUSE || is_reset)) begin
      auto_d = 1'b0;
    end
    // a latched error does not stop the running sequence
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags, write one to clear, set wins

  wire light_event = (vis_ready || uv_ready) && light_interrupt_enable;
  wire cmd_event   = cmd_taken && cmd_interrupt_enable;

  always_comb begin
    cmd_flag_d    = cmd_flag_q;
    light_field_d = light_field_q;
    if (wr_flags) begin
      cmd_flag_d    = cmd_flag_q && !reg_wdata[mailbox_pkg::CMD_FLAG_BIT];
      light_field_d = light_field_q
                    & ~reg_wdata[mailbox_pkg::LIGHT_FIELD_MSB:mailbox_pkg::LIGHT_FIELD_LSB];
    end
    if (cmd_event) begin
      cmd_flag_d = 1'b1;
    end
    if (light_event) begin
      light_field_d = light_field_d | mailbox_pkg::LIGHT_FIELD_SET;
    end
  end

  wire int_active = (cmd_flag_q && cmd_interrupt_enable)
                 || ((|light_field_q) && light_interrupt_enable);

  assign int_pin_out = 1'b0;
  assign int_pin_oe  = int_active && int_output_enable;

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      command_q  <= mailbox_pkg::RST_COMMAND;
      response_q <= mailbox_pkg::RST_RESPONSE;
      auto_q     <= 1'b0;
    end else begin
      if (exec_start) begin
        command_q <= reg_wdata;
      end
      response_q <= response_d;
      auto_q     <= auto_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_flag_q    <= 1'b0;
      light_field_q <= 2'h0;
    end else begin
      cmd_flag_q    <= cmd_flag_d;
      light_field_q <= light_field_d;
    end
  end

  // standby ends only on a command write; reads and other writes leave it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awake_q <= 1'b0;
    end else if (wr_cmd) begin
      awake_q <= 1'b1;
    end else if (!exec_busy && !exec_done && !auto_q) begin
      awake_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      force_q     <= 1'b0;
      reset_cmd_q <= 1'b0;
    end else begin
      force_q     <= cmd_good && (command_q == mailbox_pkg::CMD_FORCE);
      reset_cmd_q <= cmd_good && is_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result registers, newest measurement overwrites

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      visible_q <= {mailbox_pkg::RST_RESULT, mailbox_pkg::RST_RESULT};
    end else if (vis_ready) begin
      visible_q <= visible_result_in;
    end else begin
      if (wr_vis_l) begin
        visible_q[7:0] <= reg_wdata;
      end
      if (wr_vis_h) begin
        visible_q[15:8] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      infrared_q <= mailbox_pkg::RST_RESULT;
    end else if (ir_ready) begin
      infrared_q <= infrared_result_in;
    end else if (wr_ir_l) begin
      infrared_q <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [7:0] rd_mux;

  always_comb begin
    case (reg_addr)
      mailbox_pkg::OFF_COMMAND:   rd_mux = command_q;
      mailbox_pkg::OFF_RESPONSE:  rd_mux = response_q;
      mailbox_pkg::OFF_IRQ_FLAGS: rd_mux = {2'h0, cmd_flag_q, 3'h0, light_field_q};
      mailbox_pkg::OFF_VIS_LOW:   rd_mux = visible_q[7:0];
      mailbox_pkg::OFF_VIS_HIGH:  rd_mux = visible_q[15:8];
      mailbox_pkg::OFF_IR_LOW:    rd_mux = infrared_q;
      default:                    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  assign awake              = awake_q;
  assign auto_run           = auto_q;
  assign force_pulse        = force_q;
  assign device_reset_pulse = reset_cmd_q;

endmodule : sensor_command_mailbox

// ---- design/mailbox_pkg.sv ----
// Purpose: shared constants for the sensor command mailbox
// Assumes: byte-wide register port fed by the serial front end
// Notes:   command codes other than the error codes are plain defaults
package mailbox_pkg;

  // register offsets
  localparam logic [7:0] OFF_COMMAND      = 8'h18;
  localparam logic [7:0] OFF_RESPONSE     = 8'h20;
  localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h21;
  localparam logic [7:0] OFF_VIS_LOW      = 8'h22;
  localparam logic [7:0] OFF_VIS_HIGH     = 8'h23;
  localparam logic [7:0] OFF_IR_LOW       = 8'h24;

  // reset values
  localparam logic [7:0] RST_COMMAND      = 8'h00;
  localparam logic [7:0] RST_RESPONSE     = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS    = 8'h00;
  localparam logic [7:0] RST_RESULT       = 8'h00;

  // interrupt flag field positions
  localparam int         CMD_FLAG_BIT     = 5;
  localparam int         LIGHT_FIELD_LSB  = 0;
  localparam int         LIGHT_FIELD_MSB  = 1;
  localparam logic [1:0] LIGHT_FIELD_SET  = 2'h1;

  // response layout and error codes
  localparam int         RESP_ERR_BIT     = 7;
  localparam int         RESP_CNT_MSB     = 3;
  localparam logic [7:0] ERR_INVALID_CMD  = 8'h80;
  localparam logic [7:0] ERR_IR_OVERFLOW  = 8'h8D;
  localparam logic [7:0] ERR_AUX_OVERFLOW = 8'h8E;

  // command codes
  localparam logic [7:0] CMD_NO_OPERATION = 8'h00;
  localparam logic [7:0] CMD_RESET        = 8'h01;
  localparam logic [7:0] CMD_FORCE        = 8'h06;
  localparam logic [7:0] CMD_PAUSE        = 8'h0A;
  localparam logic [7:0] CMD_AUTO         = 8'h0E;

  // timing
  localparam int         EXEC_CYCLES      = 2;

  typedef enum logic [1:0] {
    EXEC_IDLE,
    EXEC_WAIT,
    EXEC_RUN
  } exec_state_t;

endpackage : mailbox_pkg

// ---- design/command_executor.sv ----
// Purpose: paces one command from mailbox write to completion
// Assumes: meas_busy comes from the measurement engine on the same clock
// Notes:   a command waits while a measurement is in progress
module command_executor #(
  parameter int EXEC_CYCLES = mailbox_pkg::EXEC_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic start,
  input  wire logic meas_busy,
  output logic      busy,
  output logic      done
);

  if (EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad_exec_cycles
    $error("EXEC_CYCLES out of range");
  end

  localparam logic [7:0] EXEC_LAST = 8'(EXEC_CYCLES - 1);

  mailbox_pkg::exec_state_t state_q;
  mailbox_pkg::exec_state_t state_d;
  logic [7:0]               cnt_q;
  logic [7:0]               cnt_d;
  logic                     done_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    case (state_q)
      mailbox_pkg::EXEC_IDLE: begin
        if (start) begin
          state_d = mailbox_pkg::EXEC_WAIT;
        end
      end
      mailbox_pkg::EXEC_WAIT: begin
        if (!meas_busy) begin
          state_d = mailbox_pkg::EXEC_RUN;
          cnt_d   = 8'h00;
        end
      end
      mailbox_pkg::EXEC_RUN: begin
        if (cnt_q == EXEC_LAST) begin
          state_d = mailbox_pkg::EXEC_IDLE;
          done_d  = 1'b1;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      default: begin
        state_d = mailbox_pkg::EXEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= mailbox_pkg::EXEC_IDLE;
      cnt_q   <= 8'h00;
      done    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      done    <= done_d;
    end
  end

  assign busy = (state_q != mailbox_pkg::EXEC_IDLE);

endmodule : command_executor

// ---- verification/host_model.sv ----
// Purpose: host model issuing byte reads and writes on the register port
// Assumes: one request per call, changed just after a rising edge
// Notes:   write data is inverted once the strobe drops
module host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk);
    #1;
    {reg_wdata, reg_wr} = {~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask : rd
  // waits for the rolling counter to move instead of a fixed delay
  task automatic poll(input logic [7:0] old, output logic [7:0] d);
    int n;
    n = 0;
    d = old;
    while (d === old && n < 64) begin
      rd(mailbox_pkg::OFF_RESPONSE, d);
      n++;
    end
  endtask : poll
endmodule : host_model

// ---- verification/mailbox_sva.sv ----
// Purpose: port assertions for the command mailbox
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound onto the top module
module mailbox_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port and inputs
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_rvalid,
  input wire logic       int_output_enable,
  input wire logic       light_interrupt_enable,
  input wire logic       cmd_interrupt_enable,
  input wire logic       vis_ready,
  // outputs
  input wire logic       awake,
  input wire logic       force_pulse,
  input wire logic       device_reset_pulse,
  input wire logic       int_pin_out,
  input wire logic       int_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  oe_gate_a: assert property (!int_output_enable |-> !int_pin_oe)
    else $error("pin driven without output enable");
  pin_low_a: assert property (int_pin_oe |-> int_pin_out == 1'b0)
    else $error("pin driven high");
  pin_cause_a: assert property (int_pin_oe |-> cmd_interrupt_enable || light_interrupt_enable)
    else $error("pin asserted with no enable");
  wake_cause_a: assert property ($rose(awake) |-> $past(reg_wr)
    && $past(reg_addr) == mailbox_pkg::OFF_COMMAND) else $error("woke without command write");
  force_once_a: assert property (force_pulse |=> !force_pulse)
    else $error("force pulse too long");
  reset_once_a: assert property (device_reset_pulse |=> !device_reset_pulse)
    else $error("reset pulse too long");
  light_raise_a: assert property (vis_ready && light_interrupt_enable && int_output_enable
    ##1 light_interrupt_enable && int_output_enable |-> int_pin_oe) else $error("no light irq");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read data without a read");
endmodule : mailbox_sva
bind sensor_command_mailbox mailbox_sva i_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
  .int_output_enable(int_output_enable), .light_interrupt_enable(light_interrupt_enable),
  .cmd_interrupt_enable(cmd_interrupt_enable), .vis_ready(vis_ready), .awake(awake),
  .force_pulse(force_pulse), .device_reset_pulse(device_reset_pulse),
  .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the command mailbox
// Assumes: command execution shortened to one cycle
// Notes:   reads are compared by a monitor against a queue
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst, oe_en, light_en, cmd_en, meas_busy;
  logic       reg_wr, reg_rd, reg_rvalid, awake, auto_run, pin_oe, pin_out, frc, drst;
  logic [4:0]  evs;
  logic [15:0] vis_in;
  logic [7:0]  ir_in, reg_addr, reg_wdata, reg_rdata, r, v8;
  logic [7:0]  a_q[$], e_q[$];
  logic [31:0] rv;
  logic [7:0]  offs[7] = '{8'h18, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30};
  int         miscompares, n_tests, cyc, seed, n_frc, n_drst;
  ////////////////////////////////////////////////////////////////
  host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  sensor_command_mailbox #(.EXEC_CYCLES(1)) i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .int_output_enable(oe_en), .light_interrupt_enable(light_en),
    .cmd_interrupt_enable(cmd_en), .meas_busy(meas_busy), .vis_ready(evs[0]),
    .uv_ready(evs[1]), .visible_result_in(vis_in), .ir_ready(evs[2]),
    .infrared_result_in(ir_in), .ir_overflow(evs[3]), .aux_overflow(evs[4]),
    .awake(awake), .auto_run(auto_run), .force_pulse(frc), .device_reset_pulse(drst),
    .int_pin_out(pin_out), .int_pin_oe(pin_oe));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (frc === 1'b1) n_frc++;
    if (drst === 1'b1) n_drst++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
    if (reg_rvalid === 1'b1 && e_q.size() > 0) begin
      chk($sformatf("reg %h", a_q.pop_front()), e_q.pop_front(), reg_rdata);
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic rdq(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    a_q.push_back(a);
    e_q.push_back(e);
    i_host.rd(a, d);
  endtask : rdq
  task automatic cmd(input logic [7:0] c, inout logic [7:0] x);
    i_host.wr(mailbox_pkg::OFF_COMMAND, c);
    i_host.poll(x, x);
    // let the last unqueued read pass the monitor
    @(posedge clk);
    #1;
  endtask : cmd
  task automatic ev(input logic [4:0] m);
    @(posedge clk);
    #1 evs = m;
    @(posedge clk);
    #1 evs = '0;
  endtask : ev
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hea22;
    {oe_en, light_en, cmd_en, meas_busy, evs, vis_in, ir_in} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    foreach (offs[i]) rdq(offs[i], 8'h00);
    chk("awake", 8'h00, {7'h00, awake});
    i_host.wr(mailbox_pkg::OFF_RESPONSE, 8'h05);
    rdq(mailbox_pkg::OFF_RESPONSE, 8'h05);
    chk("awake", 8'h00, {7'h00, awake});
    {oe_en, cmd_en} = 2'b11;
    r = 8'h05;
    cmd(mailbox_pkg::CMD_FORCE, r);
    chk("response", 8'h06, r);
    chk("force_pulse", 8'h01, 8'(n_frc));
    rdq(mailbox_pkg::OFF_IRQ_FLAGS, 8'h20);
    chk("pin", 8'h01, {7'h00, pin_oe});
    chk("pin_level", 8'h00, {7'h00, pin_out});
    i_host.wr(mailbox_pkg::OFF_IRQ_FLAGS, 8'h20);
    rdq(mailbox_pkg::OFF_IRQ_FLAGS, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v8 = {4'h0, r[3:0] + 4'h1};
      cmd(mailbox_pkg::CMD_NO_OPERATION, r);
      chk("counter", v8, r);
    end
    cmd(8'h55, r);
    chk("invalid", mailbox_pkg::ERR_INVALID_CMD, r);
    chk("err_msb", 8'h01, {7'h00, r[7]});
    i_host.wr(mailbox_pkg::OFF_COMMAND, mailbox_pkg::CMD_AUTO);
    repeat (12) @(posedge clk);
    rdq(mailbox_pkg::OFF_RESPONSE, 8'h80);
    chk("auto_run", 8'h00, {7'h00, auto_run});
    cmd(mailbox_pkg::CMD_NO_OPERATION, r);
    chk("cleared", 8'h01, r);
    meas_busy = 1'b1;
    i_host.wr(mailbox_pkg::OFF_COMMAND, mailbox_pkg::CMD_AUTO);
    repeat (12) @(posedge clk);
    rdq(mailbox_pkg::OFF_RESPONSE, 8'h01);
    chk("awake", 8'h01, {7'h00, awake});
    meas_busy = 1'b0;
    i_host.poll(r, r);
    chk("busy_done", 8'h02, r);
    chk("auto_run", 8'h01, {7'h00, auto_run});
    ev(5'h08);
    rdq(mailbox_pkg::OFF_RESPONSE, mailbox_pkg::ERR_IR_OVERFLOW);
    chk("auto_kept", 8'h01, {7'h00, auto_run});
    ev(5'h10);
    rdq(mailbox_pkg::OFF_RESPONSE, mailbox_pkg::ERR_AUX_OVERFLOW);
    ev(5'h18);
    rdq(mailbox_pkg::OFF_RESPONSE, mailbox_pkg::ERR_IR_OVERFLOW);
    r = 8'h8D;
    cmd(mailbox_pkg::CMD_RESET, r);
    chk("reset_cmd", 8'h00, r);
    chk("reset_pulse", 8'h01, 8'(n_drst));
    {cmd_en, light_en} = 2'b01;
    ev(5'h02);
    // command flag still stands from the earlier commands
    rdq(mailbox_pkg::OFF_IRQ_FLAGS, {6'h08, mailbox_pkg::LIGHT_FIELD_SET});
    i_host.wr(mailbox_pkg::OFF_IRQ_FLAGS, 8'h23);
    for (int i = 0; i < 4; i++) begin
      rv = $random(seed);
      vis_in = rv[15:0];
      ir_in = rv[23:16];
      ev(5'h05);
      chk("pin", 8'h01, {7'h00, pin_oe});
      rdq(mailbox_pkg::OFF_VIS_LOW, rv[7:0]);
      rdq(mailbox_pkg::OFF_VIS_HIGH, rv[15:8]);
      rdq(mailbox_pkg::OFF_IR_LOW, rv[23:16]);
      i_host.wr(mailbox_pkg::OFF_IRQ_FLAGS, 8'h03);
      rdq(mailbox_pkg::OFF_IRQ_FLAGS, 8'h00);
    end
    light_en = 1'b0;
    ev(5'h01);
    rdq(mailbox_pkg::OFF_IRQ_FLAGS, 8'h00);
    {oe_en, light_en} = 2'b01;
    ev(5'h01);
    chk("pin_off", 8'h00, {7'h00, pin_oe});
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule : tb
